// >>> include/crmc_consts.svh
// Constants of the rear-connector measurement control block.
// Assumes inclusion by bare name from design files.
`ifndef CRMC_CONSTS_SVH
`define CRMC_CONSTS_SVH

// Register byte offsets on the Avalon slave
`define CRMC_OFS_CTRL 4'h0
`define CRMC_OFS_AVG 4'h4
`define CRMC_OFS_STATUS 4'h8
`define CRMC_OFS_RESULT 4'hC

// Control register field positions
`define CRMC_CTRL_KIND_LSB 0
`define CRMC_CTRL_VARIANT 3
`define CRMC_CTRL_EXT_REF 4
`define CRMC_CTRL_REF_LSB 5
`define CRMC_CTRL_REAR_ARM 7
`define CRMC_CTRL_SRC_A 8
`define CRMC_CTRL_SRC_B 9
`define CRMC_CTRL_SHAPE_A 10
`define CRMC_CTRL_SHAPE_B 11
`define CRMC_CTRL_FRONT_ARM 12
`define CRMC_CTRL_RST_USED 13
`define CRMC_CTRL_RESET 32'h0000_1000
`define CRMC_AVG_RESET 2'h0

// Timing
`define CRMC_CLK_NS 10
`define CRMC_TICK_NS 1000
`define CRMC_TICK_CYC (`CRMC_TICK_NS / `CRMC_CLK_NS)
`define CRMC_PRESCALE_SHIFT 4

// Display
`define CRMC_DIGITS_V1 8
`define CRMC_DIGITS_V2 12
`define CRMC_ANN_V1 6
`define CRMC_ANN_V2 8
`define CRMC_LAMP_DIGIT 4'h8

`endif

// >>> include/crmc_pin_if.sv
// Synchronised rear and front pin levels passed from the synchroniser to the core.
// Assumes both ends run on the same clock.
`default_nettype none
interface crmc_pin_if;
    logic reset_n;
    logic arm_n;
    logic prescale_n;
    logic ext_ref;
    logic ch_a_front;
    logic ch_a_rear;
    logic ch_b_front;
    logic ch_b_rear;
    modport sync_side (output reset_n, arm_n, prescale_n, ext_ref, ch_a_front, ch_a_rear, ch_b_front, ch_b_rear);
    modport core_side (input reset_n, arm_n, prescale_n, ext_ref, ch_a_front, ch_a_rear, ch_b_front, ch_b_rear);
endinterface
`default_nettype wire

// >>> include/crmc_pkg.sv
// Types shared by the measurement control block.
// Assumes nothing of its surroundings.
`default_nettype none
package crmc_pkg;
    typedef enum logic [2:0] {
        channel_one_frequency_mode = 3'h0,
        channel_one_interval_mode = 3'h1,
        two_channel_quotient_mode = 3'h2,
        channel_one_event_sum_mode = 3'h3,
        channel_two_frequency_mode = 3'h4
    } crmc_kind_e;

    typedef enum logic [3:0] {
        ST_HOLD = 4'b0001,
        ST_WAIT_ARM = 4'b0010,
        ST_MEASURE = 4'b0100,
        ST_LATCH = 4'b1000
    } crmc_state_e;

    typedef enum logic [1:0] {
        REF_1MHZ = 2'h0,
        REF_5MHZ = 2'h1,
        REF_10MHZ = 2'h2
    } crmc_ref_e;
endpackage
`default_nettype wire

// >>> tb/crmc_core_bench.sv
// Self-checking bench of crmc_core with the far-side model.
// Assumes one 100 MHz clock; the run takes about 28k cycles.
`default_nettype none
module crmc_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0, front = 1'b0;
    logic [3:0] avs_address_i = 4'h0;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, rd, seed = 32'h1558_9914;
    logic avs_waitrequest_o, reset_n_i, arm_n_i, prescale_n_i, ext_ref_i, ch_a_rear_i, ch_b_rear_i;
    logic gate_n_o, shaped_a_front_o, button_lamp_o, ok;
    logic [47:0] digit_o;
    logic [11:0] point_o;
    logic [7:0] annunciator_o, ref_half = 8'h0, sig_half = 8'h5;
    logic rst_low = 1'b0, arm_low = 1'b0, pre_low = 1'b0;
    logic [2:0] k;
    int error_cnt = 0, cmp_count = 0, cyc = 0, n, g, h, sc;
    crmc_core #(.W(32)) crmc_core_inst (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .reset_n_i(reset_n_i),
        .arm_n_i(arm_n_i), .prescale_n_i(prescale_n_i), .ext_ref_i(ext_ref_i), .ch_a_front_i(front),
        .ch_a_rear_i(ch_a_rear_i), .ch_b_front_i(!front), .ch_b_rear_i(ch_b_rear_i), .gate_n_o(gate_n_o),
        .shaped_a_rear_o(), .shaped_a_front_o(shaped_a_front_o), .shaped_b_rear_o(), .shaped_b_front_o(),
        .digit_o(digit_o), .point_o(point_o), .annunciator_o(annunciator_o), .button_lamp_o(button_lamp_o));
    crmc_far_model crmc_far_model_inst (.clk_i(clk_i), .reset_low_i(rst_low), .arm_low_i(arm_low),
        .prescale_low_i(pre_low), .ref_half_i(ref_half), .sig_half_i(sig_half), .reset_n_o(reset_n_i),
        .arm_n_o(arm_n_i), .prescale_n_o(prescale_n_i), .ext_ref_o(ext_ref_i), .ch_a_rear_o(ch_a_rear_i),
        .ch_b_rear_o(ch_b_rear_i));
    always #5 clk_i = ~clk_i;
    // Front pins toggle every cycle, so a wrong source shows in the count
    always @(posedge clk_i) begin
        front <= !front;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic close_out();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Edges of a half period hh within a gate of 9 to 10 ticks, shifted by sh
    function automatic logic rate_ok(input logic [31:0] v, input int hh, input int sh);
        return v >= ((900 / (2 * hh) - 1) << sh) && v <= ((1000 / (2 * hh) + 1) << sh);
    endfunction
    task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] q);
        int t;
        t = 0;
        avs_address_i <= adr;
        avs_writedata_i <= wd;
        avs_read_i <= !wr;
        avs_write_i <= wr;
        do begin
            @(posedge clk_i);
            t++;
        end while (avs_waitrequest_o !== 1'b0 && t < 100);
        if (t >= 100) error_cnt++;
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_gate(input logic lvl, input int lim, output logic hit);
        hit = 1'b0;
        for (n = 0; n < lim && !hit; n++) begin
            @(negedge clk_i);
            hit = (gate_n_o === lvl);
        end
        @(posedge clk_i);
    endtask
    // Skips the running gate, times a whole one, reads the result
    task automatic meas();
        wait_gate(1'b1, 3000, ok);
        wait_gate(1'b0, 3000, ok);
        wait_gate(1'b1, 3000, ok);
        g = n;
        bus(1'b0, 4'hC, 32'h0, rd);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        bus(1'b0, 4'h0, 32'h0, rd);
        chk(rd, 32'h1000);
        bus(1'b0, 4'h4, 32'h0, rd);
        chk(rd, 32'h0);
        bus(1'b1, 4'h6, 32'hFFFF_FFFF, rd);
        bus(1'b0, 4'h6, 32'h0, rd);
        chk(rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            h = 5 + seed[2:0];
            k = seed[4] ? 3'h4 : 3'h0;
            sc = (seed[3] && !seed[4]) ? 4 : 0;
            sig_half <= h[7:0];
            pre_low <= seed[3];
            bus(1'b1, 4'h0, {29'h7C, k}, rd);
            meas();
            chk(g >= 900 && g <= 1010, 1'b1);
            chk(rate_ok(rd, h, sc), 1'b1);
        end
        pre_low <= 1'b0;
        for (int j = 0; j < 3; j++) begin
            ref_half <= (j == 0) ? 8'd50 : ((j == 1) ? 8'd10 : 8'd5);
            bus(1'b1, 4'h0, 32'hF90 | (j << 5), rd);
            meas();
            chk(g >= 900 && g <= 1010, 1'b1);
        end
        ref_half <= 8'h0;
        wait_gate(1'b0, 3000, ok);
        wait_gate(1'b1, 3000, ok);
        chk(ok, 1'b0);
        rst_low <= 1'b1;
        wait_gate(1'b1, 8, ok);
        chk(ok, 1'b1);
        bus(1'b1, 4'h0, 32'hF81, rd);
        repeat (12) @(posedge clk_i);
        chk({digit_o[31:0], point_o[7:0], annunciator_o[5:0]}, {32'h8888_8888, 8'hFF, 6'h3F});
        rst_low <= 1'b0;
        wait_gate(1'b0, 20, ok);
        chk({ok, annunciator_o}, 9'h102);
        arm_low <= 1'b1;
        wait_gate(1'b1, 3000, ok);
        wait_gate(1'b0, 1500, ok);
        chk(ok, 1'b0);
        arm_low <= 1'b0;
        wait_gate(1'b0, 20, ok);
        chk(ok, 1'b1);
        bus(1'b1, 4'h0, 32'hF00, rd);
        wait_gate(1'b1, 3000, ok);
        wait_gate(1'b0, 1500, ok);
        chk(ok, 1'b0);
        arm_low <= 1'b1;
        bus(1'b1, 4'h0, 32'h1F00, rd);
        wait_gate(1'b0, 30, ok);
        chk(ok, 1'b1);
        bus(1'b1, 4'h0, 32'h3F08, rd);
        wait_gate(1'b1, 3000, ok);
        wait_gate(1'b0, 1500, ok);
        chk(ok, 1'b0);
        arm_low <= 1'b0;
        wait_gate(1'b0, 30, ok);
        chk(ok, 1'b1);
        rst_low <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk({digit_o, point_o, annunciator_o, button_lamp_o}, {48'h8888_8888_8888, 12'hFFF, 9'h1FF});
        rst_low <= 1'b0;
        bus(1'b1, 4'h0, 32'h1F0B, rd);
        wait_gate(1'b0, 30, ok);
        rst_low <= 1'b1;
        repeat (12) @(posedge clk_i);
        chk({gate_n_o, annunciator_o, shaped_a_front_o}, 10'h010);
        close_out();
    end
endmodule
`default_nettype wire

// >>> tb/crmc_core_properties.sv
// Checker of crmc_core, bound to its ports.
// Assumes CTRL changes only through Avalon writes that it sees.
`default_nettype none
module crmc_core_properties (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic avs_waitrequest_o,
    input wire logic reset_n_i,
    input wire logic arm_n_i,
    input wire logic gate_n_o,
    input wire logic shaped_a_rear_o,
    input wire logic shaped_a_front_o,
    input wire logic shaped_b_rear_o,
    input wire logic shaped_b_front_o,
    input wire logic [47:0] digit_o,
    input wire logic [11:0] point_o,
    input wire logic [7:0] annunciator_o,
    input wire logic button_lamp_o
);
    logic [13:0] ctrl;
    logic [3:0] age;
    logic lamp_en;
    logic settled;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    assign lamp_en = !ctrl[3] || ctrl[13];
    assign settled = age[3];
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= 14'h1000;
        end else if (avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0) begin
            ctrl <= avs_writedata_i[13:0];
        end
    end
    // Settings take a few cycles through the core, so rules wait for them
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            age <= 4'h0;
        end else if (avs_write_i && !avs_waitrequest_o) begin
            age <= 4'h0;
        end else if (!age[3]) begin
            age <= age + 4'h1;
        end
    end
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_lamp;
        (!reset_n_i && lamp_en && settled) [*5];
    endsequence
    sequence s_run;
        ((reset_n_i || !lamp_en) && settled) [*5];
    endsequence
    a_wait_one: assert property (s_req |=> !avs_waitrequest_o)
        else $error("waitrequest stayed high after a request");
    a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
        else $error("waitrequest low too long");
    a_wait_cause: assert property ($fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
        else $error("waitrequest fell with no request");
    a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i[1:0] != 2'h0
        |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
    a_gate_abort: assert property (s_lamp |-> gate_n_o)
        else $error("gate active while reset pin low");
    a_lamp_first: assert property (s_lamp ##0 !ctrl[3] |-> digit_o[31:0] == 32'h8888_8888
        && point_o[7:0] == 8'hFF && annunciator_o[5:0] == 6'h3F) else $error("first lamp test wrong");
    a_lamp_second: assert property (s_lamp ##0 ctrl[3] |-> digit_o == 48'h8888_8888_8888
        && point_o == 12'hFFF && annunciator_o == 8'hFF && button_lamp_o) else $error("second lamp test wrong");
    a_kind_shown: assert property (s_run |-> annunciator_o == (8'h01 << ctrl[2:0]))
        else $error("annunciator not the kind");
    a_arm_hold: assert property ((!arm_n_i && (ctrl[3] || ctrl[7]) && settled) [*5] |-> !$fell(gate_n_o))
        else $error("gate started while rear arming low");
    a_front_hold: assert property ((!ctrl[12] && (ctrl[3] || !ctrl[7]) && settled) [*3]
        |-> !$fell(gate_n_o)) else $error("gate started while front arming off");
    a_shaped_route: assert property (settled |-> (ctrl[10] ? !shaped_a_front_o : !shaped_a_rear_o)
        && (ctrl[11] ? !shaped_b_front_o : !shaped_b_rear_o)) else $error("unrouted shaped copy active");
endmodule
bind crmc_core crmc_core_properties crmc_core_properties_inst (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .reset_n_i(reset_n_i), .arm_n_i(arm_n_i), .gate_n_o(gate_n_o), .shaped_a_rear_o(shaped_a_rear_o),
    .shaped_a_front_o(shaped_a_front_o), .digit_o(digit_o), .point_o(point_o), .annunciator_o(annunciator_o),
    .button_lamp_o(button_lamp_o), .shaped_b_rear_o(shaped_b_rear_o), .shaped_b_front_o(shaped_b_front_o));
`default_nettype wire

// >>> tb/crmc_far_model.sv
// System logic on the far side of the rear connector.
// Assumes the bench commands levels and half periods in clock cycles.
`default_nettype none
module crmc_far_model (
    input wire logic clk_i,
    input wire logic reset_low_i,
    input wire logic arm_low_i,
    input wire logic prescale_low_i,
    input wire logic [7:0] ref_half_i,
    input wire logic [7:0] sig_half_i,
    output logic reset_n_o = 1'b1,
    output logic arm_n_o = 1'b1,
    output logic prescale_n_o = 1'b1,
    output logic ext_ref_o = 1'b0,
    output logic ch_a_rear_o = 1'b0,
    output logic ch_b_rear_o = 1'b1
);
    logic [7:0] ref_cnt = 8'h1;
    logic [7:0] sig_cnt = 8'h1;
    // Pulse width is whatever the bench holds, shortened since the device never times it
    always @(posedge clk_i) begin
        reset_n_o <= !reset_low_i;
        arm_n_o <= !arm_low_i;
        prescale_n_o <= !prescale_low_i;
    end
    // A stopped reference stands still
    always @(posedge clk_i) begin
        if (ref_half_i == 8'h0 || ref_cnt >= ref_half_i) begin
            ref_cnt <= 8'h1;
            ext_ref_o <= (ref_half_i == 8'h0) ? ext_ref_o : !ext_ref_o;
        end else begin
            ref_cnt <= ref_cnt + 8'h1;
        end
    end
    always @(posedge clk_i) begin
        if (sig_cnt >= sig_half_i) begin
            sig_cnt <= 8'h1;
            ch_a_rear_o <= !ch_a_rear_o;
            ch_b_rear_o <= !ch_b_rear_o;
        end else begin
            sig_cnt <= sig_cnt + 8'h1;
        end
    end
endmodule
`default_nettype wire

// >>> verilog/crmc_core.sv
// Rear-connector measurement control: timebase, arming, gate, routing, lamp test.
// Assumes an Avalon-MM master with waitrequest and asynchronous connector pins.
`default_nettype none
`include "crmc_consts.svh"
// Summary of operation
// - An external 1, 5 or 10 MHz reference replaces the internal timebase when it is selected.
// - A low prescale line multiplies the result by 16 in channel-one frequency, interval, quotient and event-sum modes, not in channel-two frequency mode.
// - A low reset line aborts the measurement in progress at once.
// - While reset is low the first variant shows eight with point on all eight digits and all six annunciators.
// - When reset returns high a fresh measurement starts with the current settings.
// - A low arming line withholds the start of a measurement until it returns high.
// - In the first variant a rear-routed arming line replaces the front panel arming control.
// - The gate output is low for the whole of each measurement and high otherwise.
// - Each channel takes its rear input when its source switch selects the rear path, else the front one.
// - Each channel's conditioned copy goes to the rear or the front output, never both.
// - While reset is low the second variant lights twelve eights with points, eight annunciators and the buttons.
// - In the second variant an unconnected reset line counts as high.
// - In the second variant rear and front arming combine so that either low inhibits measurement.
module crmc_core #(
    parameter int W = 32
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic reset_n_i,
    input wire logic arm_n_i,
    input wire logic prescale_n_i,
    input wire logic ext_ref_i,
    input wire logic ch_a_front_i,
    input wire logic ch_a_rear_i,
    input wire logic ch_b_front_i,
    input wire logic ch_b_rear_i,
    output logic gate_n_o,
    output logic shaped_a_rear_o,
    output logic shaped_a_front_o,
    output logic shaped_b_rear_o,
    output logic shaped_b_front_o,
    output logic [47:0] digit_o,
    output logic [11:0] point_o,
    output logic [7:0] annunciator_o,
    output logic button_lamp_o
);
    import crmc_pkg::*;

    crmc_pin_if pin_if ();

    crmc_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pins_i({ch_b_rear_i, ch_b_front_i, ch_a_rear_i, ch_a_front_i, ext_ref_i, prescale_n_i, arm_n_i, reset_n_i}),
        .pin_if(pin_if.sync_side)
    );

    function automatic logic [W-1:0] gate_len(input logic [1:0] avg);
        case (avg)
            2'h0: gate_len = W'(10);
            2'h1: gate_len = W'(100);
            2'h2: gate_len = W'(1000);
            default: gate_len = W'(10000);
        endcase
    endfunction

    function automatic logic [3:0] ref_div(input logic [1:0] sel);
        case (sel)
            REF_5MHZ: ref_div = 4'h5;
            REF_10MHZ: ref_div = 4'hA;
            default: ref_div = 4'h1;
        endcase
    endfunction

    logic [31:0] ctrl;
    logic [1:0] avg;
    crmc_state_e state;
    crmc_kind_e kind;
    logic variant2;
    logic [W-1:0] tick_cnt;
    logic [W-1:0] evt_cnt;
    logic [W-1:0] result;
    logic [W-1:0] scaled;
    logic [6:0] int_div;
    logic [3:0] ext_div;
    logic ext_prev;
    logic a_prev;
    logic b_prev;
    logic interval_open;
    logic tick;
    logic sig_a;
    logic sig_b;
    logic a_rise;
    logic b_rise;
    logic reset_active;
    logic armed;
    logic gate_done;
    logic bus_req;
    logic bus_take;

    assign kind = crmc_kind_e'(ctrl[`CRMC_CTRL_KIND_LSB +: 3]);
    assign variant2 = ctrl[`CRMC_CTRL_VARIANT];

    assign sig_a = ctrl[`CRMC_CTRL_SRC_A] ? pin_if.ch_a_rear : pin_if.ch_a_front;
    assign sig_b = ctrl[`CRMC_CTRL_SRC_B] ? pin_if.ch_b_rear : pin_if.ch_b_front;
    assign a_rise = sig_a && !a_prev;
    assign b_rise = sig_b && !b_prev;

    // Second variant with nothing wired to the line behaves as if it were high
    assign reset_active = !pin_if.reset_n && !(variant2 && !ctrl[`CRMC_CTRL_RST_USED]);

    always_comb begin
        if (variant2) begin
            armed = pin_if.arm_n && ctrl[`CRMC_CTRL_FRONT_ARM];
        end else if (ctrl[`CRMC_CTRL_REAR_ARM]) begin
            armed = pin_if.arm_n;
        end else begin
            armed = ctrl[`CRMC_CTRL_FRONT_ARM];
        end
    end

    // Timebase: one tick per microsecond from either source
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_div <= 7'h00;
            ext_div <= 4'h0;
            ext_prev <= 1'b0;
            tick <= 1'b0;
        end else begin
            ext_prev <= pin_if.ext_ref;
            tick <= 1'b0;
            if (ctrl[`CRMC_CTRL_EXT_REF]) begin
                int_div <= 7'h00;
                if (pin_if.ext_ref && !ext_prev) begin
                    if (ext_div >= ref_div(ctrl[`CRMC_CTRL_REF_LSB +: 2]) - 4'h1) begin
                        ext_div <= 4'h0;
                        tick <= 1'b1;
                    end else begin
                        ext_div <= ext_div + 4'h1;
                    end
                end
            end else begin
                ext_div <= 4'h0;
                if (int_div == 7'(`CRMC_TICK_CYC - 1)) begin
                    int_div <= 7'h00;
                    tick <= 1'b1;
                end else begin
                    int_div <= int_div + 7'h01;
                end
            end
        end
    end

    always_comb begin
        case (kind)
            channel_one_interval_mode: gate_done = interval_open && a_rise;
            two_channel_quotient_mode: gate_done = (evt_cnt == gate_len(avg)) && a_rise;
            channel_one_event_sum_mode: gate_done = 1'b0;
            default: gate_done = tick && (tick_cnt == gate_len(avg) - W'(1));
        endcase
    end

    // Measurement sequence
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_HOLD;
            tick_cnt <= '0;
            evt_cnt <= '0;
            interval_open <= 1'b0;
            a_prev <= 1'b0;
            b_prev <= 1'b0;
            gate_n_o <= 1'b1;
            result <= '0;
        end else begin
            a_prev <= sig_a;
            b_prev <= sig_b;
            if (reset_active) begin
                state <= ST_HOLD;
                tick_cnt <= '0;
                evt_cnt <= '0;
                interval_open <= 1'b0;
                gate_n_o <= 1'b1;
            end else begin
                case (state)
                    ST_HOLD: begin
                        state <= ST_WAIT_ARM;
                    end
                    ST_WAIT_ARM: begin
                        tick_cnt <= '0;
                        evt_cnt <= '0;
                        interval_open <= 1'b0;
                        if (armed) begin
                            state <= ST_MEASURE;
                            gate_n_o <= 1'b0;
                        end
                    end
                    ST_MEASURE: begin
                        if (tick) begin
                            tick_cnt <= tick_cnt + W'(1);
                        end
                        case (kind)
                            channel_one_interval_mode: if (a_rise) interval_open <= 1'b1;
                            two_channel_quotient_mode: if (a_rise) evt_cnt <= evt_cnt + W'(1);
                            channel_two_frequency_mode: if (b_rise) evt_cnt <= evt_cnt + W'(1);
                            default: if (a_rise) evt_cnt <= evt_cnt + W'(1);
                        endcase
                        if (kind == channel_one_event_sum_mode) begin
                            result <= evt_cnt;
                        end
                        if (gate_done) begin
                            state <= ST_LATCH;
                            gate_n_o <= 1'b1;
                        end
                    end
                    ST_LATCH: begin
                        result <= (kind == channel_one_interval_mode) ? tick_cnt : evt_cnt;
                        state <= ST_WAIT_ARM;
                    end
                    default: begin
                        state <= ST_HOLD;
                    end
                endcase
            end
        end
    end

    crmc_scale #(.W(W)) u_scale (
        .raw_i(result),
        .kind_i(kind),
        .prescale_n_i(pin_if.prescale_n),
        .scaled_o(scaled)
    );

    // Shaped copies: one destination only, the other held low
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shaped_a_rear_o <= 1'b0;
            shaped_a_front_o <= 1'b0;
            shaped_b_rear_o <= 1'b0;
            shaped_b_front_o <= 1'b0;
        end else begin
            shaped_a_rear_o <= ctrl[`CRMC_CTRL_SHAPE_A] && sig_a;
            shaped_a_front_o <= !ctrl[`CRMC_CTRL_SHAPE_A] && sig_a;
            shaped_b_rear_o <= ctrl[`CRMC_CTRL_SHAPE_B] && sig_b;
            shaped_b_front_o <= !ctrl[`CRMC_CTRL_SHAPE_B] && sig_b;
        end
    end

    // Display and lamp test
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            digit_o <= '0;
            point_o <= '0;
            annunciator_o <= '0;
            button_lamp_o <= 1'b0;
        end else if (reset_active) begin
            for (int i = 0; i < `CRMC_DIGITS_V2; i++) begin
                if (variant2 || i < `CRMC_DIGITS_V1) begin
                    digit_o[i*4 +: 4] <= `CRMC_LAMP_DIGIT;
                    point_o[i] <= 1'b1;
                end else begin
                    digit_o[i*4 +: 4] <= 4'h0;
                    point_o[i] <= 1'b0;
                end
            end
            annunciator_o <= variant2 ? 8'hFF : 8'h3F;
            button_lamp_o <= variant2;
        end else begin
            digit_o <= {16'h0000, 32'(scaled)};
            point_o <= '0;
            annunciator_o <= 8'h01 << kind;
            button_lamp_o <= 1'b0;
        end
    end

    // Avalon slave: one wait state, answer at the second edge of the request
    assign bus_req = avs_read_i || avs_write_i;
    assign bus_take = bus_req && !avs_waitrequest_o;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h0000_0000;
        end else begin
            avs_waitrequest_o <= !(bus_req && avs_waitrequest_o);
            if (avs_read_i && avs_waitrequest_o) begin
                case (avs_address_i)
                    `CRMC_OFS_CTRL: avs_readdata_o <= {18'h0, ctrl[13:0]};
                    `CRMC_OFS_AVG: avs_readdata_o <= {30'h0, avg};
                    `CRMC_OFS_STATUS: avs_readdata_o <= {25'h0, pin_if.prescale_n, armed, reset_active, state};
                    `CRMC_OFS_RESULT: avs_readdata_o <= 32'(scaled);
                    default: avs_readdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl <= `CRMC_CTRL_RESET;
            avg <= `CRMC_AVG_RESET;
        end else if (bus_take && avs_write_i) begin
            if (avs_address_i == `CRMC_OFS_CTRL) begin
                ctrl <= {18'h0, avs_writedata_i[13:0]};
            end
            if (avs_address_i == `CRMC_OFS_AVG) begin
                avg <= avs_writedata_i[1:0];
            end
        end
    end
endmodule
`default_nettype wire

// >>> verilog/crmc_scale.sv
// Result scaling for an external divide-by-16 prescaler.
// Assumes a same-clock, already synchronised prescale level.
`default_nettype none
`include "crmc_consts.svh"
module crmc_scale #(
    parameter int W = 32
) (
    input wire logic [W-1:0] raw_i,
    input wire crmc_pkg::crmc_kind_e kind_i,
    input wire logic prescale_n_i,
    output logic [W-1:0] scaled_o
);
    import crmc_pkg::*;
    logic applies;

    always_comb begin
        case (kind_i)
            channel_one_frequency_mode,
            channel_one_interval_mode,
            two_channel_quotient_mode,
            channel_one_event_sum_mode: applies = 1'b1;
            default: applies = 1'b0;
        endcase
    end

    // Upper bits drop off; the counter width must leave room for the factor
    assign scaled_o = (applies && !prescale_n_i) ? (raw_i << `CRMC_PRESCALE_SHIFT) : raw_i;
endmodule
`default_nettype wire

// >>> verilog/crmc_sync.sv
// Two-stage synchroniser for every asynchronous pin of the block.
// Assumes pins are unrelated to clk_i; reset levels match the pins' idle levels.
`default_nettype none
module crmc_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] pins_i,
    crmc_pin_if.sync_side pin_if
);
    // Idle levels: reset, arm and prescale lines rest high
    localparam logic [7:0] IDLE = 8'h07;
    logic [7:0] meta;
    logic [7:0] stable;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta <= IDLE;
            stable <= IDLE;
        end else begin
            meta <= pins_i;
            stable <= meta;
        end
    end

    assign pin_if.reset_n = stable[0];
    assign pin_if.arm_n = stable[1];
    assign pin_if.prescale_n = stable[2];
    assign pin_if.ext_ref = stable[3];
    assign pin_if.ch_a_front = stable[4];
    assign pin_if.ch_a_rear = stable[5];
    assign pin_if.ch_b_front = stable[6];
    assign pin_if.ch_b_rear = stable[7];
endmodule
`default_nettype wire
